// ===== ewp_pkg.sv
// Shared constants and types for the serial EEPROM slave with block protect
`default_nettype none

package ewp_pkg;

  // ---------------------------------------------------------------
  // Clock and internal write timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned INTERNAL_WRITE_TIME_MS = 5;
  localparam int unsigned TWR_CYC = INTERNAL_WRITE_TIME_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // Slave address and array geometry
  // ---------------------------------------------------------------
  localparam logic [2:0] DEV_FIXED = 3'h1;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned MEM_BYTES = 16384;
  localparam int unsigned PAGE_BYTES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ---------------------------------------------------------------
  // Address word and block_protect_config layout
  // ---------------------------------------------------------------
  localparam int unsigned AHI_TARGET = 7;
  localparam int unsigned CFG_PROTECT_ENABLE = 3;
  localparam int unsigned CFG_BLOCK_SELECT_HI = 2;
  localparam int unsigned CFG_BLOCK_SELECT_LO = 1;
  localparam int unsigned CFG_PROTECT_LOCK = 0;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [3:0] CFG_UPPER_ZERO = 4'h0;

  // ---------------------------------------------------------------
  // Link timing in SCL edges; write FIFO depth and width
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W = 14;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDATA,
    ST_RD,
    ST_IGN
  } ewp_state_t;

endpackage

`default_nettype wire

// ===== ewp_slave.sv
// Serial EEPROM slave with page buffer, write cycle and block protect
//
// What this block does
// (RULE1) Start is SDA fall with SCL high; stop is SDA rise with SCL high.
// (RULE2) Respond only when the seven address bits match type code and 001.
// (RULE3) Eighth address bit: one reads from the device, zero writes to it.
// (RULE4) Matching slave address is acknowledged by holding SDA low in clock 9.
// (RULE5) Address bytes always acked; data bytes acked only when unprotected.
// (RULE6) Read bytes shift out, SDA freed in clock 9, master ack continues.
// (RULE7) Byte write: address, two address bytes, data, stop starts the write.
// (RULE8) During the internal write the slave address is never acknowledged.
// (RULE9) 256 pages of 64 bytes; bits 13..6 page, bits 5..0 byte in page.
// (RULE10) Page write counter increments per byte and wraps inside the page.
// (RULE11) Address bit 15 picks protect register over array; bit 14 ignored.
// (RULE12) Protect register: enable bit 3, block select 2..1, lock bit 0.
// (RULE13) Protection disabled lets writes land anywhere in the array.
// (RULE14) Block select picks upper quarter, half, three quarters or all.
// (RULE15) Once lock is one the protect bits can never change again.
// (RULE16) Write to protected address: data byte not acked, write dropped.
// (RULE17) Protect register written by byte write; data bits 7..4 ignored.
// (RULE18) More than one data byte to the protect register cancels the write.
// (RULE19) Read with no address phase returns the byte at current address.
// (RULE20) Selective read loads the 14 address bits then reads that byte.
// (RULE21) Sequential reads step through the array and wrap at its end.
// (RULE22) Reads with bit 15 set return the protect register, repeatedly.
// (RULE23) Delivered state: array bytes read ff, protect register reads 00.
// (RULE24) Stop starts a timed busy interval; array bytes commit early in it, the register at its end.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Small ready/valid FIFO
// ---------------------------------------------------------------
module ewp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ewp_fifo_regs_t;

  ewp_fifo_regs_t r, n;
  logic [W-1:0] mem [D];
  logic push, pop;

  always_comb begin
    n = r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wp] <= in_data;
    end
  end

  assign in_ready = (r.cnt != (AW + 1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = mem[r.rp];
endmodule // ewp_fifo

// ---------------------------------------------------------------
// Slave top
// ---------------------------------------------------------------
module ewp_slave #(
  // Type code value is arbitrary
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int unsigned TWR_CYCLES = ewp_pkg::TWR_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    ewp_pkg::ewp_state_t st;
    logic [3:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic oe;
    logic sda_o;
    logic acked;
    logic go_rd;
    logic mack;
    logic [13:0] addr;
    logic sel;
    logic wr_any;
    logic wr_multi;
    logic [3:0] reg_pend;
    logic busy;
    logic commit_reg;
    logic [31:0] bcnt;
    logic [5:0] widx;
    logic wdone;
    logic [63:0] mask;
    logic [1:0] pace;
  } ewp_regs_t;

  ewp_regs_t r, n;
  logic [1:0] rst_sync_r;
  logic rst_q_n;

  // Storage has no reset: it must survive a bus reset like real cells
  // (RULE23) Delivered erased state, given at declaration so that the
  // clocked writer below stays the only process that assigns storage
  logic [7:0] mem [ewp_pkg::MEM_BYTES] = '{default: ewp_pkg::ERASED_BYTE};
  logic [7:0] pbuf [ewp_pkg::PAGE_BYTES];
  logic [3:0] cfg_r = ewp_pkg::CFG_RESET;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic push, f_in_ready, f_out_valid, f_out_ready;
  logic [13:0] push_data, f_out_data;
  logic pb_we, mem_we, reg_we, prot_now;

  // (RULE14) Upper-region decode of the read-only window
  function automatic logic prot_hit(input logic [3:0] cfg,
                                    input logic [13:0] a);
    logic [1:0] bs;
    bs = {cfg[ewp_pkg::CFG_BLOCK_SELECT_HI],
          cfg[ewp_pkg::CFG_BLOCK_SELECT_LO]};
    // (RULE13) Enable off means nothing protected
    if (!cfg[ewp_pkg::CFG_PROTECT_ENABLE]) begin
      return 1'b0;
    end
    case (bs)
      2'b00: return a[13:12] == 2'b11;
      2'b01: return a[13];
      2'b10: return a[13:12] != 2'b00;
      default: return 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q_n = rst_sync_r[1];

  // ---------------------------------------------------------------
  // Bus conditions from synchronised pins
  // ---------------------------------------------------------------
  assign scl = r.s2[1];
  assign sda = r.s2[0];
  assign scl_rise = r.s2[1] && !r.s3[1];
  assign scl_fall = !r.s2[1] && r.s3[1];
  // (RULE1) Start and stop only while SCL stays high
  assign start_c = scl && r.s3[1] && r.s3[0] && !sda;
  assign stop_c = scl && r.s3[1] && !r.s3[0] && sda;
  assign prot_now = prot_hit(cfg_r, r.addr);

  // Page buffer filling is paced; the FIFO absorbs the slack
  assign f_out_ready = (r.pace == 2'b00) && !r.busy;
  assign pb_we = f_out_valid && f_out_ready;
  // (RULE24) Commit walk runs once the FIFO has drained
  assign mem_we = r.busy && !r.commit_reg && !f_out_valid && !r.wdone &&
                  r.mask[r.widx];
  assign reg_we = r.busy && r.commit_reg && (r.bcnt == '0);

  ewp_fifo #(
    .W(ewp_pkg::FIFO_W),
    .D(ewp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_q_n),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(push_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ---------------------------------------------------------------
  // Protocol and write cycle
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    push = 1'b0;
    push_data = {r.addr[5:0], r.rx};
    n.s1 = {scl_i, sda_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.sda_o = 1'b0;
    n.pace = r.pace + 2'b01;
    if (pb_we) begin
      n.mask[f_out_data[13:8]] = 1'b1;
    end
    if (r.busy) begin
      if (r.bcnt != '0) begin
        n.bcnt = r.bcnt - 32'h1;
      end
      if (!r.commit_reg && !f_out_valid && !r.wdone) begin
        if (r.widx == 6'h3f) begin
          n.wdone = 1'b1;
        end else begin
          n.widx = r.widx + 6'h01;
        end
      end
      if (r.bcnt == '0 && r.wdone) begin
        n.busy = 1'b0;
      end
    end
    if (start_c) begin
      n.st = ewp_pkg::ST_DEV;
      n.cnt = '0;
      n.oe = 1'b0;
    end else if (stop_c) begin
      n.st = ewp_pkg::ST_IDLE;
      n.oe = 1'b0;
      n.sel = 1'b0;
      // (RULE7) Stop launches the internal write
      if (r.st == ewp_pkg::ST_WDATA && r.wr_any) begin
        // (RULE18) Extra protect data cancels the cycle
        if (!(r.sel && r.wr_multi)) begin
          n.busy = 1'b1;
          n.commit_reg = r.sel;
          n.bcnt = TWR_CYCLES;
          n.widx = '0;
          n.wdone = r.sel;
        end
      end
    end else if (r.st == ewp_pkg::ST_IDLE || r.st == ewp_pkg::ST_IGN) begin
      n.oe = 1'b0;
    end else if (scl_rise) begin
      if (r.cnt < ewp_pkg::BIT_ACK) begin
        n.rx = {r.rx[6:0], sda};
      end else begin
        // (RULE6) Master ack sampled in clock 9
        n.mack = !sda;
      end
      n.cnt = r.cnt + 4'h1;
    end else if (scl_fall) begin
      if (r.cnt == ewp_pkg::BIT_ACK) begin
        n.oe = 1'b0;
        n.acked = 1'b0;
        case (r.st)
          ewp_pkg::ST_DEV: begin
            // (RULE2) (RULE8) Match only when idle
            n.acked = (r.rx[7:1] == {DEV_TYPE, ewp_pkg::DEV_FIXED}) &&
                      !r.busy;
            // (RULE4) Drive ack through clock 9
            n.oe = n.acked;
            // (RULE3) Direction bit
            n.go_rd = r.rx[0];
          end
          ewp_pkg::ST_AHI: begin
            // (RULE11) Target select, bit 14 dropped
            n.sel = r.rx[ewp_pkg::AHI_TARGET];
            n.addr[13:8] = r.rx[5:0];
            n.acked = 1'b1;
            n.oe = 1'b1;
          end
          ewp_pkg::ST_ALO: begin
            // (RULE5) (RULE20) Address bytes acked and loaded
            n.addr[7:0] = r.rx;
            n.mask = '0;
            n.wr_any = 1'b0;
            n.wr_multi = 1'b0;
            n.acked = 1'b1;
            n.oe = 1'b1;
          end
          ewp_pkg::ST_WDATA: begin
            if (r.sel) begin
              // (RULE15) (RULE17) Locked register refuses, low nibble kept
              n.acked = !cfg_r[ewp_pkg::CFG_PROTECT_LOCK];
              if (n.acked) begin
                n.reg_pend = r.rx[3:0];
                n.wr_multi = r.wr_any;
                n.wr_any = 1'b1;
              end
            end else begin
              // (RULE16) Protected byte is refused and dropped
              n.acked = !prot_now && f_in_ready;
              if (n.acked) begin
                push = 1'b1;
                // (RULE10) Counter wraps inside the page
                n.addr[5:0] = r.addr[5:0] + 6'h01;
                n.wr_any = 1'b1;
              end
            end
            n.oe = n.acked;
          end
          default: begin
            // (RULE6) Release SDA for the master's ack
            n.oe = 1'b0;
          end
        endcase
      end else if (r.cnt == ewp_pkg::BIT_END) begin
        n.cnt = '0;
        n.oe = 1'b0;
        case (r.st)
          ewp_pkg::ST_DEV: begin
            n.st = !r.acked ? ewp_pkg::ST_IGN :
                   (r.go_rd ? ewp_pkg::ST_RD : ewp_pkg::ST_AHI);
          end
          ewp_pkg::ST_AHI: n.st = ewp_pkg::ST_ALO;
          ewp_pkg::ST_ALO: n.st = ewp_pkg::ST_WDATA;
          ewp_pkg::ST_WDATA: begin
            n.st = r.acked ? ewp_pkg::ST_WDATA : ewp_pkg::ST_IGN;
          end
          default: begin
            n.st = r.mack ? ewp_pkg::ST_RD : ewp_pkg::ST_IGN;
          end
        endcase
        if (n.st == ewp_pkg::ST_RD) begin
          // (RULE19) (RULE22) Register or current array byte
          if (r.sel) begin
            n.tx = {ewp_pkg::CFG_UPPER_ZERO, cfg_r};
          end else begin
            n.tx = mem[r.addr];
            // (RULE21) Full-array wrap
            n.addr = r.addr + 14'h0001;
          end
          n.oe = !n.tx[7];
        end
      end else if (r.st == ewp_pkg::ST_RD) begin
        n.oe = !r.tx[3'(7 - r.cnt)];
      end else begin
        n.oe = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Storage writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (pb_we) begin
      pbuf[f_out_data[13:8]] <= f_out_data[7:0];
    end
    // (RULE9) Page from bits 13..6, byte from the walk index
    if (mem_we) begin
      mem[{r.addr[13:6], r.widx}] <= pbuf[r.widx];
    end
    // (RULE12) Only bits 3..0 are stored
    if (reg_we) begin
      cfg_r <= r.reg_pend;
    end
  end

  assign sda_oe = r.oe;
  assign sda_o = r.sda_o;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_OE_ON_FALL: assert property (@(posedge ref_clk) // (RULE1)
    disable iff (!rst_q_n)
    $changed(r.oe) |-> $past(scl_fall) || $past(start_c) ||
                      $past(stop_c))
    else $error("SDA drive changed away from an SCL fall");

  AST_DEV_ACK: assert property (@(posedge ref_clk) // (RULE4)
    disable iff (!rst_q_n)
    (scl_fall && r.st == ewp_pkg::ST_DEV && r.cnt == ewp_pkg::BIT_ACK &&
     r.rx[7:1] == {DEV_TYPE, ewp_pkg::DEV_FIXED} && !r.busy &&
     !start_c && !stop_c) |=> r.oe && r.acked)
    else $error("Matching address not acknowledged");

  AST_BUSY_NACK: assert property (@(posedge ref_clk) // (RULE8)
    disable iff (!rst_q_n)
    (scl_fall && r.st == ewp_pkg::ST_DEV && r.cnt == ewp_pkg::BIT_ACK &&
     r.busy) |=> !r.oe ##1 !r.oe)
    else $error("Address acknowledged during write cycle");

  AST_PROT_NACK: assert property (@(posedge ref_clk) // (RULE16)
    disable iff (!rst_q_n)
    (scl_fall && r.st == ewp_pkg::ST_WDATA && r.cnt == ewp_pkg::BIT_ACK &&
     !r.sel && prot_now) |-> !push ##1 !r.oe)
    else $error("Protected data byte acknowledged");

  AST_RD_RELEASE: assert property (@(posedge ref_clk) // (RULE6)
    disable iff (!rst_q_n)
    (scl_fall && r.st == ewp_pkg::ST_RD && r.cnt == ewp_pkg::BIT_ACK &&
     !start_c && !stop_c) |=> !r.oe)
    else $error("SDA held during master ack slot");

  AST_LOCK_HOLD: assert property (@(posedge ref_clk) // (RULE15)
    disable iff (!rst_q_n)
    cfg_r[ewp_pkg::CFG_PROTECT_LOCK] |=> $stable(cfg_r))
    else $error("Locked protect bits changed");

  AST_PAGE_WRAP: assert property (@(posedge ref_clk) // (RULE10)
    disable iff (!rst_q_n)
    push |=> r.addr[13:6] == $past(r.addr[13:6]) &&
             r.addr[5:0] == $past(r.addr[5:0]) + 6'h01)
    else $error("Page write counter left its page");

  AST_WRITE_LAUNCH: assert property (@(posedge ref_clk) // (RULE7)
    disable iff (!rst_q_n)
    (stop_c && r.st == ewp_pkg::ST_WDATA && r.wr_any && !r.sel) |=>
    r.busy && r.bcnt == TWR_CYCLES)
    else $error("Stop did not start the write cycle");

  AST_SEQ_INC: assert property (@(posedge ref_clk) // (RULE21)
    disable iff (!rst_q_n)
    (scl_fall && r.cnt == ewp_pkg::BIT_END && !r.sel &&
     n.st == ewp_pkg::ST_RD && !start_c && !stop_c) |=>
    r.addr == $past(r.addr) + 14'h0001)
    else $error("Read address did not advance");

  AST_REG_UPPER: assert property (@(posedge ref_clk) // (RULE12)
    disable iff (!rst_q_n)
    (r.st == ewp_pkg::ST_RD && r.sel) |-> r.tx[7:4] == 4'h0)
    else $error("Protect register upper bits not zero");

endmodule // ewp_slave

`default_nettype wire

// ===== ewp_master.sv
// Behavioural bus master that drives the clock and data lines of the slave
`timescale 1ns/1ps
`default_nettype none

module ewp_master (
  input wire logic ref_clk,
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Clock line idles high between frames, data line released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bit timing: a quarter of the 160 ns link clock
  // ---------------------------------------------------------------
  task automatic quarter();
    repeat (10) @(posedge ref_clk);
  endtask

  // start condition
  // Also works as a repeated start from clock low
  task automatic start();
    sda_oe <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_oe <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask

  task automatic stop();
    sda_oe <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_oe <= 1'b0;
    quarter();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    quarter();
    scl <= 1'b1;
    quarter();
    r = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask

  // ninth bit: release for slave ack, or master ack/no-ack
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask
endmodule // ewp_master

`default_nettype wire

// ===== ewp_slave_bench.sv
// Self-checking bench for the EEPROM slave with block protect
`timescale 1ns/1ps
`default_nettype none

module ewp_slave_bench;
  localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary type code
  localparam int unsigned INTERNAL_WRITE_TIME = 1000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic m_oe;
  logic d_oe;
  logic d_o;
  logic sda;
  int failures = 0;
  int num_checks = 0;

  always #2 ref_clk = ~ref_clk;
  // Open drain wire with pull-up
  assign sda = (d_oe ? d_o : 1'b1) & ~m_oe;

  ewp_slave #(.DEV_TYPE(TYPE_CODE), .TWR_CYCLES(INTERNAL_WRITE_TIME)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(d_o), .sda_oe(d_oe));
  ewp_master m (.ref_clk(ref_clk), .scl(scl), .sda_oe(m_oe), .sda(sda));

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ackd(input logic k, input logic e);
    chk({7'h0, k}, {7'h0, e});
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic [7:0] rx;
    m.xfer(b, 1'b1, rx, ack);
  endtask

  task automatic open(input logic rd, output logic ack);
    m.start();
    byte_out({TYPE_CODE, 3'b001, rd}, ack);
  endtask

  task automatic aim(input logic [15:0] a);
    logic k;
    open(1'b0, k);
    ackd(k, 1'b1);
    byte_out(a[15:8], k);
    ackd(k, 1'b1);
    byte_out(a[7:0], k);
    ackd(k, 1'b1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d[$],
                    input logic e);
    logic k;
    aim(a);
    foreach (d[i]) begin
      byte_out(d[i], k);
      ackd(k, e);
    end
    m.stop();
  endtask

  // Selective read when sel is set, else a current-address read
  task automatic rd(input logic sel, input logic [15:0] a,
                    input logic [7:0] e[$]);
    logic k;
    logic [7:0] d;
    logic a9;
    if (sel) aim(a);
    open(1'b1, k);
    ackd(k, 1'b1);
    foreach (e[i]) begin
      m.xfer(8'hff, (i + 1 >= e.size()), d, a9);
      chk(d, e[i]);
    end
    m.stop();
  endtask

  task automatic poll(input logic e);
    logic k;
    open(1'b0, k);
    ackd(k, e);
    m.stop();
  endtask

  // Long enough for the timed write and the page commit to finish
  task automatic settle();
    repeat (INTERNAL_WRITE_TIME + 300) @(posedge ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_delivered();
    rd(1'b1, 16'h0000, '{8'hff, 8'hff});
    rd(1'b1, 16'h8000, '{8'h00, 8'h00});
  endtask

  task automatic t_address();
    logic k;
    m.start();
    byte_out({~TYPE_CODE, 3'b001, 1'b0}, k);
    ackd(k, 1'b0);
    m.stop();
    m.start();
    byte_out({TYPE_CODE, 3'b011, 1'b1}, k);
    ackd(k, 1'b0);
    m.stop();
  endtask

  task automatic t_byte_write();
    wr(16'h0123, '{8'h5a}, 1'b1);
    poll(1'b0);
    settle();
    poll(1'b1);
    rd(1'b1, 16'h4123, '{8'h5a});
    rd(1'b1, 16'h0122, '{8'hff});
    rd(1'b0, 16'h0000, '{8'h5a});
  endtask

  task automatic t_page();
    wr(16'h3ffe, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
    settle();
    rd(1'b1, 16'h3ffe, '{8'h11, 8'h22, 8'hff});
    rd(1'b1, 16'h7fc0, '{8'h33, 8'h44});
  endtask

  // Lock is permanent, so this runs last
  task automatic t_protect();
    logic [15:0] lim;
    for (int i = 0; i < 4; i++) begin
      lim = 16'h3000 - 16'(i) * 16'h1000;
      wr(16'h8000, '{8'hf8 | 8'(i << 1)}, 1'b1);
      settle();
      rd(1'b1, 16'hc000, '{8'h08 | 8'(i << 1)});
      wr(lim, '{8'h77}, 1'b0);
      if (i < 3) begin
        wr(lim - 16'h1, '{8'h66}, 1'b1);
        settle();
        rd(1'b1, lim - 16'h1, '{8'h66, 8'hff});
      end
    end
    wr(16'h8000, '{8'h00}, 1'b1);
    settle();
    wr(16'h3000, '{8'h77}, 1'b1);
    settle();
    rd(1'b1, 16'h3000, '{8'h77});
    wr(16'h8000, '{8'h09, 8'h09}, 1'b1);
    poll(1'b1);
    rd(1'b1, 16'h8000, '{8'h00});
    wr(16'h8000, '{8'h01}, 1'b1);
    settle();
    wr(16'h8000, '{8'h08}, 1'b0);
    rd(1'b1, 16'h8000, '{8'h01, 8'h01});
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_delivered();
    t_address();
    t_byte_write();
    t_page();
    t_protect();
    tally_and_finish();
  end

  // Scenarios need under 90k cycles; this cuts a hang short
  initial begin
    repeat (95000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule // ewp_slave_bench

`default_nettype wire
